// ---- sbd_map.svh ----
// Constant definitions for the stepper bridge input decoder.
`ifndef SBD_MAP_SVH
`define SBD_MAP_SVH
`define SBD_FADE_NS 2000
`define SBD_CLK_NS 10
`define SBD_FADE_CYC ((`SBD_FADE_NS + `SBD_CLK_NS - 1) / `SBD_CLK_NS)
`define SBD_CNT_W 8
`define SBD_PWM_W 4
`define SBD_PWM_MAX 4'hF
`endif

// ---- sbd_pkg.sv ----
// Types shared by the stepper bridge input decoder.
package sbd_pkg;
  typedef struct packed {
    logic fwd;
    logic rev;
  } sbd_pair_t;
  typedef struct packed {
    logic pos;
    logic neg;
  } sbd_drive_t;
  typedef enum logic [2:0] {
    SBD_IDLE = 3'h1,
    SBD_FWD = 3'h2,
    SBD_REV = 3'h4
  } sbd_lock_t;
  typedef enum logic [2:0] {
    SBD_OFF = 3'h1,
    SBD_RUN = 3'h2,
    SBD_FADE = 3'h4
  } sbd_soft_t;
endpackage

// ---- sbd_decoder.sv ----
// Stepper bridge input decoder with interlocked four-input mode and phase mode.
// Overview of operation
// - Four-input mode: each input pair sets its bridge; both low means off.
// - Pair forward high first, reverse later: keep driving positive-high.
// - Pair reverse high first, forward later: keep driving negative-high.
// - Second pair has its own first-arrival interlock, independent of first.
// - Phase mode: enable low turns all off; phases select the bridge polarity.
// - With soft-off fitted, outputs fade off gradually on entering standby.
`include "sbd_map.svh"
module sbd_decoder
  import sbd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_phase_mode,
  input wire logic i_soft_off_fitted,
  input wire logic i_pair_a_forward_in,
  input wire logic i_pair_a_reverse_in,
  input wire logic i_pair_b_forward_in,
  input wire logic i_pair_b_reverse_in,
  input wire logic i_drive_enable_in,
  output logic [3:0] o_bridge_out,
  output logic [3:0] o_bridge_oe
);
  logic [1:0][1:0] sync1_reg, sync2_reg;
  logic en1_reg, en2_reg;
  sbd_lock_t [1:0] lock_reg, lock_next;
  sbd_soft_t soft_reg, soft_next;
  logic [`SBD_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`SBD_PWM_W-1:0] pwm_reg, pwm_next;
  logic [3:0] lvl, oe, last_reg, last_next, out_reg, out_next, oe_reg, oe_next;
  sbd_pair_t [1:0] pin;
  always_ff @(posedge i_clk) begin
    // Pins come from outside the clock domain, so two stages before use.
    sync1_reg <= {{i_pair_b_forward_in, i_pair_b_reverse_in},
                  {i_pair_a_forward_in, i_pair_a_reverse_in}};
    sync2_reg <= sync1_reg;
    en1_reg <= i_drive_enable_in;
    en2_reg <= en1_reg;
  end
  assign pin = sync2_reg;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      // Whichever input rose first owns the pair while both are high.
      case (lock_reg[p])
        SBD_IDLE: lock_next[p] = pin[p].fwd ? SBD_FWD : (pin[p].rev ? SBD_REV : SBD_IDLE);
        SBD_FWD: lock_next[p] = pin[p].fwd ? SBD_FWD : (pin[p].rev ? SBD_REV : SBD_IDLE);
        SBD_REV: lock_next[p] = pin[p].rev ? SBD_REV : (pin[p].fwd ? SBD_FWD : SBD_IDLE);
        default: lock_next[p] = SBD_IDLE;
      endcase
    end
  end
  always_comb begin
    lvl = 4'h0;
    oe = 4'h0;
    if (i_phase_mode) begin
      if (en2_reg) begin
        oe = 4'hF;
        lvl[3:2] = pin[0].fwd ? 2'h1 : 2'h2;
        lvl[1:0] = pin[0].rev ? 2'h1 : 2'h2;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (lock_next[p] == SBD_FWD) begin
          oe[3-2*p -: 2] = 2'h3;
          lvl[3-2*p -: 2] = 2'h2;
        end else if (lock_next[p] == SBD_REV) begin
          oe[3-2*p -: 2] = 2'h3;
          lvl[3-2*p -: 2] = 2'h1;
        end
      end
    end
  end
  always_comb begin
    soft_next = soft_reg;
    cnt_next = cnt_reg;
    pwm_next = pwm_reg + 4'h1;
    last_next = last_reg;
    out_next = lvl;
    oe_next = oe;
    case (soft_reg)
      SBD_OFF: if (i_phase_mode && en2_reg) soft_next = SBD_RUN;
      SBD_RUN: begin
        if (i_phase_mode && en2_reg) begin
          last_next = lvl;
        end else begin
          // Without the fitted option the drive drops at once.
          soft_next = i_soft_off_fitted ? SBD_FADE : SBD_OFF;
          cnt_next = `SBD_CNT_W'(`SBD_FADE_CYC);
          // Hold the last levels so the fade does not start with a dead cycle.
          if (i_soft_off_fitted) begin
            out_next = last_reg;
            oe_next = 4'hF;
          end
        end
      end
      SBD_FADE: begin
        // Duty shrinks with the count so the winding current tapers off.
        out_next = last_reg;
        oe_next = (pwm_reg < cnt_reg[`SBD_CNT_W-1 -: `SBD_PWM_W]) ? 4'hF : 4'h0;
        cnt_next = cnt_reg - `SBD_CNT_W'(1);
        if (i_phase_mode && en2_reg) soft_next = SBD_RUN;
        else if (cnt_reg == `SBD_CNT_W'(0)) soft_next = SBD_OFF;
        if (i_phase_mode && en2_reg) begin
          out_next = lvl;
          oe_next = oe;
        end
      end
      default: soft_next = SBD_OFF;
    endcase
    if (!i_phase_mode) soft_next = SBD_OFF;
    out_next = out_next & oe_next;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lock_reg <= {SBD_IDLE, SBD_IDLE};
      soft_reg <= SBD_OFF;
      cnt_reg <= `SBD_CNT_W'(0);
      pwm_reg <= `SBD_PWM_W'(0);
      last_reg <= 4'h0;
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      lock_reg <= lock_next;
      soft_reg <= soft_next;
      cnt_reg <= cnt_next;
      pwm_reg <= pwm_next;
      last_reg <= last_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end
  assign o_bridge_out = out_reg;
  assign o_bridge_oe = oe_reg;
endmodule

// ---- sbd_decoder_monitor.sv ----
// Port checker for the stepper bridge input decoder.
module sbd_decoder_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_phase_mode,
  input wire logic i_soft_off_fitted,
  input wire logic i_pair_a_forward_in,
  input wire logic i_pair_a_reverse_in,
  input wire logic i_pair_b_forward_in,
  input wire logic i_pair_b_reverse_in,
  input wire logic i_drive_enable_in,
  input wire logic [3:0] o_bridge_out,
  input wire logic [3:0] o_bridge_oe
);
  wire fa = i_pair_a_forward_in, ra = i_pair_a_reverse_in, pm = i_phase_mode;
  wire fb = i_pair_b_forward_in, rb = i_pair_b_reverse_in, en = i_drive_enable_in;
  logic [3:0] rst_q;
  // Outputs lag the pins by three cycles, so pre-reset samples must age out first.
  always_ff @(posedge i_clk) rst_q <= {rst_q[2:0], i_rst};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst || rst_q != 4'h0);
  property p_pair; !pm && $past(fa,3) != $past(ra,3) |-> o_bridge_out[3:2] == {$past(fa,3),
    $past(ra,3)} && o_bridge_oe[3:2] == 2'h3; endproperty
  a_pair: assert property (p_pair) else $error("pair a drive wrong");
  property p_idle; !pm && !$past(fb,3) && !$past(rb,3) |-> o_bridge_oe[1:0] == 2'h0; endproperty
  a_idle: assert property (p_idle) else $error("pair b not off");
  property p_first_a; !pm && $past(fa,4) && !$past(ra,4) && $past(fa,3) && $past(ra,3)
    |-> o_bridge_out[3:2] == 2'h2; endproperty
  a_first_a: assert property (p_first_a) else $error("later reverse obeyed");
  property p_first_b; !pm && $past(rb,4) && !$past(fb,4) && $past(fb,3) && $past(rb,3)
    |-> o_bridge_out[1:0] == 2'h1; endproperty
  a_first_b: assert property (p_first_b) else $error("later forward obeyed");
  property p_phase; pm && $past(en,3) |-> o_bridge_out == {!$past(fa,3), $past(fa,3),
    !$past(ra,3), $past(ra,3)} && o_bridge_oe == 4'hF; endproperty
  a_phase: assert property (p_phase) else $error("phase map wrong");
  property p_stby; pm && !i_soft_off_fitted && !$past(en,3) |-> o_bridge_oe == 4'h0; endproperty
  a_stby: assert property (p_stby) else $error("standby not off");
  property p_soft; pm && i_soft_off_fitted && $fell(en) |-> ##[4:20] o_bridge_oe != 4'h0
    ##[150:260] o_bridge_oe == 4'h0; endproperty
  a_soft: assert property (p_soft) else $error("soft off shape wrong");
  property p_offz; (o_bridge_out & ~o_bridge_oe) == 4'h0; endproperty
  a_offz: assert property (p_offz) else $error("off pin driven");
  c_both: cover property (!pm && fa && ra);
  c_run: cover property (pm && en);
  c_fade: cover property (pm && i_soft_off_fitted && $fell(en));
endmodule
bind sbd_decoder sbd_decoder_monitor u_sbd_decoder_monitor (.*);

// ---- sbd_mcu.sv ----
// Host controller model that drives the decoder's logic pins.
module sbd_mcu (
  input wire logic i_clk,
  input wire logic [4:0] i_want,
  output logic [4:0] o_pins
);
  // Pins move just after an edge, as when firmware writes a port register.
  initial o_pins = 5'h00;
  always @(posedge i_clk) o_pins <= i_want;
endmodule

// ---- sbd_decoder_test.sv ----
// Self-checking bench for the stepper bridge input decoder.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h", $time, (a)); end end
module sbd_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, pm = 1'b0;
  logic sf = 1'b0;
  logic [4:0] want = 5'h00, pins;
  logic [3:0] out, oe;
  int bad_count = 0, total_checks = 0;
  initial forever #5 clk = ~clk;
  sbd_mcu u_sbd_mcu (.i_clk(clk), .i_want(want), .o_pins(pins));
  sbd_decoder u_sbd_decoder (.i_clk(clk), .i_rst(rst), .i_phase_mode(pm),
    .i_soft_off_fitted(sf), .i_pair_a_forward_in(pins[4]), .i_pair_a_reverse_in(pins[3]),
    .i_pair_b_forward_in(pins[2]), .i_pair_b_reverse_in(pins[1]),
    .i_drive_enable_in(pins[0]), .o_bridge_out(out), .o_bridge_oe(oe));
  task automatic put(input logic [4:0] v, input int n);
    @(posedge clk) want <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic test_pairs();
    put(5'h12, 6); `CHK({out, oe}, 8'h9F)
    put(5'h0C, 6); `CHK({out, oe}, 8'h6F)
    put(5'h10, 6); `CHK({out, oe}, 8'h8C)
    put(5'h00, 6); `CHK({out, oe}, 8'h00)
  endtask
  task automatic test_first();
    put(5'h14, 6);
    put(5'h1E, 6); `CHK({out, oe}, 8'hAF)
    put(5'h0A, 6);
    put(5'h1E, 6); `CHK({out, oe}, 8'h5F)
    put(5'h00, 6);
  endtask
  task automatic test_phase();
    @(posedge clk) pm <= 1'b1;
    put(5'h01, 6); `CHK({out, oe}, 8'hAF)
    put(5'h09, 6); `CHK({out, oe}, 8'h9F)
    put(5'h19, 6); `CHK({out, oe}, 8'h5F)
    put(5'h11, 6); `CHK({out, oe}, 8'h6F)
    put(5'h18, 6); `CHK({out, oe}, 8'h00)
  endtask
  task automatic test_soft();
    int n;
    n = 0;
    @(posedge clk) sf <= 1'b1;
    put(5'h01, 6);
    @(posedge clk) want <= 5'h00;
    repeat (230) begin
      @(posedge clk);
      n += (oe != 4'h0);
    end
    `CHK(n > 10, 1'b1)
    `CHK(oe, 4'h0)
  endtask
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_pairs();
    test_first();
    test_phase();
    test_soft();
    finish_test();
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule
